// ### dv/tmr_core_tb.sv
`include "tmr_consts.svh"
`default_nettype none
module tmr_core_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_in, resetn_in, read_in, write_in, waitrequest_out;
   logic [9:0] address_in;
   logic [31:0] writedata_in, readdata_out;
   logic [3:0] byteenable_in;
   logic osc_pin, pin_out, pin_oe, pin_ovr, ext_en, xtal_run, pin_level;
   logic [7:0] rd;
   int num_errors = 0;
   int n_tests = 0;
   int divs[7] = '{1, 8, 32, 64, 128, 256, 1024};
   int hi_cnt;

   tmr_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .address_in(address_in), .read_in(read_in),
      .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
      .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .osc_input_pin_in(osc_pin),
      .compare_output_pin_out(pin_out), .compare_output_pin_oe_out(pin_oe),
      .compare_output_override_out(pin_ovr), .ext_clock_input_en_out(ext_en),
      .crystal_osc_run_out(xtal_run));

   tmr_pin_model pin_u (.ext_en_in(ext_en), .xtal_run_in(xtal_run), .pin_in(pin_out), .pin_oe_in(pin_oe),
      .osc_out(osc_pin), .pin_level_out(pin_level));

   // --------------------------------
   // helpers
   // --------------------------------
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic in_range(input int v, input int lo, input int hi);
      n_tests++;
      if (v < lo || v > hi)
      begin
         num_errors++;
         $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      address_in <= a;
      writedata_in <= {24'h0, d};
      read_in <= ~wr;
      write_in <= wr;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (waitrequest_out !== 1'b0 && n < 100);
      if (n >= 100)
      begin
         num_errors++;
         $display("[ERR] %0t bus access not answered", $time);
      end
      rd = readdata_out[7:0];
      read_in <= 1'b0;
      write_in <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rc(input logic [9:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   // high cycles of the pin over one sampling span, after the compare buffer settles
   task automatic duty(input logic [7:0] ctrl, input logic [7:0] ocr, input int ns, input int lo, input int hi);
      wr(`TMR_IDX_OCR, ocr);
      wr(`TMR_IDX_CTRL, ctrl);
      settle(1100);
      hi_cnt = 0;
      repeat (ns)
      begin
         @(negedge clk_in);
         if (pin_level === 1'b1)
            hi_cnt++;
      end
      in_range(hi_cnt, lo, hi);
   endtask

   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   initial
   begin
      #500_000;
      num_errors++;
      stop_test();
   end

   // --------------------------------
   // scenarios
   // --------------------------------
   initial
   begin
      resetn_in = 1'b0;
      read_in = 1'b0;
      write_in = 1'b0;
      address_in = 10'h000;
      writedata_in = 32'h0;
      byteenable_in = 4'h1;
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      rc(`TMR_IDX_CTRL, 8'h00);
      rc(`TMR_IDX_CNT, 8'h00);
      rc(`TMR_IDX_OCR, 8'h00);
      rc(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h00);
      wr(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h07);
      rc(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h00);
      wr(10'h0c0, 8'h5a);
      rc(10'h0c0, 8'h00);
      // override without and with the direction bit
      wr(`TMR_IDX_CTRL, 8'h30);
      settle(3);
      chk({7'h0, pin_ovr}, 8'h01);
      chk({7'h0, pin_oe}, 8'h00);
      wr(`TMR_IDX_DIR, 8'h01);
      settle(3);
      chk({7'h0, pin_oe}, 8'h01);
      // forced matches in normal and clear-on-match modes
      wr(`TMR_IDX_CTRL, 8'hb0);
      settle(4);
      chk({7'h0, pin_level}, 8'h01);
      rc(`TMR_IDX_CTRL, 8'h30);
      wr(`TMR_IDX_CTRL, 8'ha0);
      settle(4);
      chk({7'h0, pin_level}, 8'h00);
      wr(`TMR_IDX_CTRL, 8'h90);
      settle(4);
      chk({7'h0, pin_level}, 8'h01);
      wr(`TMR_IDX_CNT, 8'h05);
      wr(`TMR_IDX_OCR, 8'h05);
      wr(`TMR_IDX_CTRL, 8'h98);
      settle(4);
      chk({7'h0, pin_level}, 8'h00);
      rc(`TMR_IDX_CNT, 8'h05);
      rc(`TMR_IDX_FLAG, 8'h00);
      // strobe in fast pwm is ignored
      wr(`TMR_IDX_CTRL, 8'hf8);
      settle(4);
      chk({7'h0, pin_level}, 8'h00);
      wr(`TMR_IDX_CTRL, 8'h00);
      settle(50);
      rc(`TMR_IDX_CNT, 8'h05);
      // ticks per prescale code
      for (int i = 0; i < 7; i++)
      begin
         wr(`TMR_IDX_CNT, 8'h00);
         wr(`TMR_IDX_CTRL, 8'(i + 1));
         repeat (divs[i] * 8) @(posedge clk_in);
         wr(`TMR_IDX_CTRL, 8'h00);
         bus(1'b0, `TMR_IDX_CNT, 8'h00);
         in_range(int'(rd), 6, 12);
      end
      // match and overflow flags, write-one clear
      wr(`TMR_IDX_CNT, 8'h00);
      wr(`TMR_IDX_OCR, 8'h10);
      wr(`TMR_IDX_FLAG, 8'h03);
      wr(`TMR_IDX_CTRL, 8'h01);
      settle(40);
      wr(`TMR_IDX_CTRL, 8'h00);
      rc(`TMR_IDX_FLAG, 8'h02);
      wr(`TMR_IDX_FLAG, 8'h02);
      rc(`TMR_IDX_FLAG, 8'h00);
      wr(`TMR_IDX_CNT, 8'hf0);
      wr(`TMR_IDX_CTRL, 8'h01);
      settle(20);
      wr(`TMR_IDX_CTRL, 8'h00);
      rc(`TMR_IDX_FLAG, 8'h01);
      // a counter write hides the match on the following tick
      wr(`TMR_IDX_FLAG, 8'h03);
      wr(`TMR_IDX_OCR, 8'h20);
      wr(`TMR_IDX_CNT, 8'h20);
      wr(`TMR_IDX_CTRL, 8'h01);
      settle(2);
      wr(`TMR_IDX_CTRL, 8'h00);
      rc(`TMR_IDX_FLAG, 8'h00);
      // clear-on-match wraps at the compare value and never reaches max
      wr(`TMR_IDX_FLAG, 8'h03);
      wr(`TMR_IDX_CNT, 8'h00);
      wr(`TMR_IDX_OCR, 8'h10);
      wr(`TMR_IDX_CTRL, 8'h09);
      settle(60);
      wr(`TMR_IDX_CTRL, 8'h00);
      bus(1'b0, `TMR_IDX_CNT, 8'h00);
      in_range(int'(rd), 0, 17);
      rc(`TMR_IDX_FLAG, 8'h02);
      // pwm waveforms
      duty(8'h69, 8'h40, 256, 60, 70);
      duty(8'h79, 8'h40, 256, 186, 196);
      duty(8'h69, 8'hff, 256, 256, 256);
      duty(8'h61, 8'h40, 510, 122, 134);
      duty(8'h71, 8'h40, 510, 376, 388);
      duty(8'h61, 8'hff, 510, 505, 510);
      wr(`TMR_IDX_CTRL, 8'h00);
      // asynchronous clocking and pending flags
      wr(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h10);
      wr(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h18);
      settle(3);
      chk({6'h0, ext_en, xtal_run}, 8'h02);
      wr(`TMR_IDX_OCR, 8'h22);
      rc(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h1a);
      for (int n = 0; n < 40 && rd[1] !== 1'b0; n++)
         bus(1'b0, `TMR_IDX_ASYNC_CLOCK_STATUS, 8'h00);
      chk(rd, 8'h18);
      rc(`TMR_IDX_OCR, 8'h22);
      // counting from the oscillator: about one step per seven system clocks
      wr(`TMR_IDX_CNT, 8'h00);
      wr(`TMR_IDX_CTRL, 8'h01);
      settle(140);
      wr(`TMR_IDX_CTRL, 8'h00);
      rd = 8'h01;
      for (int n = 0; n < 40 && rd[0] !== 1'b0; n++)
         bus(1'b0, `TMR_IDX_ASYNC_CLOCK_STATUS, 8'h00);
      bus(1'b0, `TMR_IDX_CNT, 8'h00);
      in_range(int'(rd), 16, 26);
      wr(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h08);
      settle(3);
      chk({6'h0, ext_en, xtal_run}, 8'h01);
      wr(`TMR_IDX_ASYNC_CLOCK_STATUS, 8'h00);
      settle(3);
      chk({6'h0, ext_en, xtal_run}, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire

// ### dv/tmr_pin_model.sv
`default_nettype none
module tmr_pin_model #(
   parameter int HALF_NS = 35
) (
   // oscillator control from the device
   input wire logic ext_en_in,
   input wire logic xtal_run_in,
   // pin as driven by the device
   input wire logic pin_in,
   input wire logic pin_oe_in,
   // far-side view
   output logic osc_out,
   output logic pin_level_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------------------
   // pin and oscillator
   // --------------------------------
   // board pull-down: a released pin reads low, never the last driven value
   assign pin_level_out = (pin_oe_in === 1'b1) ? pin_in : 1'b0;

   // the 35 ns half period puts every oscillator edge on a system clock edge;
   // it stands still unless the buffer or the crystal is switched on
   initial
   begin
      osc_out = 1'b0;
      forever
      begin
         #(HALF_NS);
         osc_out = (ext_en_in === 1'b1 || xtal_run_in === 1'b1) ? ~osc_out : 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### inc/tmr_consts.svh
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define TMR_IDX_CTRL 10'h0b0
`define TMR_IDX_CNT 10'h0b2
`define TMR_IDX_OCR 10'h0b3
`define TMR_IDX_ASYNC_CLOCK_STATUS 10'h0b6
`define TMR_IDX_FLAG 10'h0b7
`define TMR_IDX_DIR 10'h0b8

// ----------------------------------------
// field positions
// ----------------------------------------
`define TMR_CTRL_FORCE 7
`define TMR_CTRL_WGM0 6
`define TMR_CTRL_COM1 5
`define TMR_CTRL_COM0 4
`define TMR_CTRL_WGM1 3
`define TMR_CTRL_CS_HI 2
`define TMR_CTRL_CS_LO 0
`define TMR_ASYNC_CLOCK_STATUS_EXT_CLOCK_INPUT_EN 4
`define TMR_ASYNC_CLOCK_STATUS_AS 3
`define TMR_FLAG_OCF 1
`define TMR_FLAG_TOV 0

// ----------------------------------------
// values and counts
// ----------------------------------------
`define TMR_RESET_BYTE 8'h00
`define TMR_TOP 8'hff
`define TMR_BOTTOM 8'h00
`define TMR_ONE 8'h01
`define TMR_SYNC_EDGES 2'h2
`define TMR_MASK_DIV8 10'h007
`define TMR_MASK_DIV32 10'h01f
`define TMR_MASK_DIV64 10'h03f
`define TMR_MASK_DIV128 10'h07f
`define TMR_MASK_DIV256 10'h0ff
`define TMR_MASK_DIV1024 10'h3ff

`endif

// ### inc/tmr_pkg.sv
`default_nettype none
package tmr_pkg;
   // ----------------------------------------
   // waveform modes {bit3, bit6} of control
   // ----------------------------------------
   typedef enum logic [1:0] {
      TMR_MODE_NORMAL = 2'h0,
      TMR_MODE_PHASE = 2'h1,
      TMR_MODE_CTC = 2'h2,
      TMR_MODE_FAST = 2'h3
   } tmr_mode_t;

   // ----------------------------------------
   // clock select codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      TMR_CS_STOP = 3'h0,
      TMR_CS_DIV1 = 3'h1,
      TMR_CS_DIV8 = 3'h2,
      TMR_CS_DIV32 = 3'h3,
      TMR_CS_DIV64 = 3'h4,
      TMR_CS_DIV128 = 3'h5,
      TMR_CS_DIV256 = 3'h6,
      TMR_CS_DIV1024 = 3'h7
   } tmr_cs_t;
endpackage
`default_nettype wire

// ### rtl/tmr_core.sv
// Notes on behaviour
// (R1) force strobe acts only in normal or clear-on-match mode
// (R2) software writes the force strobe as zero while a pwm mode runs
// (R3) force strobe applies a match to the output using current action field
// (R4) forced match sets no flag and never clears the counter
// (R5) force strobe reads back as zero
// (R6) mode bits 6 and 3 choose sequence, top source and waveform
// (R7) per mode: top, compare buffer update point, overflow flag point
// (R8) nonzero action overrides port; driver enabled only with direction bit
// (R9) non-pwm action: off, toggle, clear, set on match
// (R10) fast pwm: 10 clear on match set at bottom, 11 inverse
// (R11) fast pwm with compare at top: match ignored, bottom action kept
// (R12) phase pwm: 10 clear on up match, set on down match; 11 inverse
// (R13) phase pwm with compare at top: match ignored, action done at top
// (R14) clock select 1..7: undivided, then /8 /32 /64 /128 /256 /1024
// (R15) clock select zero stops the timer
// (R16) counter read and write; a write blocks the next timer clock match
// (R17) compare value checked against counter each timer clock
// (R18) external clock buffer on when enabled and async; crystal only when off
// (R19) software sets external clock enable before selecting async clocking
// (R20) async select chooses io clock or the oscillator pin
// (R21) async writes set a pending flag, cleared once destination is loaded
// (R22) match and overflow flags set by hardware, cleared by writing one
// (R23) counter and compare reset to zero
//
// The implementer's own choice: the Avalon-MM register port.
`include "tmr_consts.svh"
`default_nettype none
module tmr_core #(
   parameter int PRE_W = 10
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // avalon-mm slave
   input wire logic [9:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [31:0] readdata_out,
   output logic waitrequest_out,
   // oscillator pin
   input wire logic osc_input_pin_in,
   // compare output pin
   output logic compare_output_pin_out,
   output logic compare_output_pin_oe_out,
   output logic compare_output_override_out,
   // oscillator control
   output logic ext_clock_input_en_out,
   output logic crystal_osc_run_out
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic wait_r;
   logic [31:0] rdata_r;
   wire do_wr = write_in & ~wait_r & byteenable_in[0];
   wire hit_ctrl = (address_in == `TMR_IDX_CTRL);
   wire hit_cnt = (address_in == `TMR_IDX_CNT);
   wire hit_ocr = (address_in == `TMR_IDX_OCR);
   wire hit_async_clock_status = (address_in == `TMR_IDX_ASYNC_CLOCK_STATUS);
   wire hit_flag = (address_in == `TMR_IDX_FLAG);
   wire hit_dir = (address_in == `TMR_IDX_DIR);
   wire [7:0] wbyte = writedata_in[7:0];

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [7:0] ctrl_r;
   logic [7:0] cnt_r;
   logic [7:0] ocr_act_r;
   logic ext_clock_input_en_r;
   logic as_r;
   logic dir_r;
   logic ocf_r;
   logic tov_r;
   logic up_r;
   logic blk_r;
   logic force_r;
   logic oc_r;
   logic osc_s1_r;
   logic osc_s2_r;
   logic osc_s3_r;
   // entry 0 control, 1 compare, 2 counter
   logic [7:0] tmp_r [3];
   logic [2:0] pend_r;
   logic [2:0] xfer_r;
   logic [1:0] ecnt_r [3];
   logic [2:0] wr_hit;
   logic tick;

   assign wr_hit = {do_wr & hit_cnt, do_wr & hit_ocr, do_wr & hit_ctrl};

   // ----------------------------------------
   // clock source
   // ----------------------------------------
   wire osc_rise = osc_s2_r & ~osc_s3_r;
   wire src_tick = as_r ? osc_rise : 1'b1; // (R20)

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_s3_r <= 1'b0;
      end
      else
      begin
         osc_s1_r <= osc_input_pin_in;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
      end
   end

   tmr_prescale #(
      .PRE_W(PRE_W)
   ) u_pre (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .src_tick_in(src_tick),
      .sel_in(tmr_pkg::tmr_cs_t'(ctrl_r[`TMR_CTRL_CS_HI:`TMR_CTRL_CS_LO])),
      .tick_out(tick)
   );

   // ----------------------------------------
   // write staging, one temporary per control, compare and counter register
   // ----------------------------------------
   // in async mode a control or counter value lands after two oscillator edges; in sync mode one cycle later; compare loads at its buffer update point
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_stage
         wire last_edge = pend_r[gi] & osc_rise & (ecnt_r[gi] == `TMR_SYNC_EDGES - 2'h1);
         always_ff @(posedge clk_in or negedge resetn_in)
         begin
            if (!resetn_in)
            begin
               tmp_r[gi] <= `TMR_RESET_BYTE;
               pend_r[gi] <= 1'b0;
               ecnt_r[gi] <= 2'h0;
               xfer_r[gi] <= 1'b0;
            end
            else
            begin
               if (wr_hit[gi])
                  tmp_r[gi] <= wbyte;
               xfer_r[gi] <= as_r ? last_edge : wr_hit[gi];
               if (wr_hit[gi] & as_r)
               begin
                  pend_r[gi] <= 1'b1; // (R21)
                  ecnt_r[gi] <= 2'h0;
               end
               // pending drops with a control or counter load itself, so software never sees those clear early
               else if (xfer_r[gi] | ~as_r)
                  pend_r[gi] <= 1'b0; // (R21)
               else if (pend_r[gi] & osc_rise)
                  ecnt_r[gi] <= ecnt_r[gi] + 2'h1;
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // counting unit
   // ----------------------------------------
   tmr_pkg::tmr_mode_t mode;
   assign mode = tmr_pkg::tmr_mode_t'({ctrl_r[`TMR_CTRL_WGM1], ctrl_r[`TMR_CTRL_WGM0]}); // (R6)
   wire [1:0] com = ctrl_r[`TMR_CTRL_COM1:`TMR_CTRL_COM0];
   wire pwm = (mode == tmr_pkg::TMR_MODE_PHASE) | (mode == tmr_pkg::TMR_MODE_FAST);
   wire is_top = (cnt_r == `TMR_TOP);
   wire is_bot = (cnt_r == `TMR_BOTTOM);
   wire match_ev = tick & (cnt_r == ocr_act_r) & ~blk_r; // (R16) (R17)
   wire special = com[1] & (ocr_act_r == `TMR_TOP);
   wire force_ev = force_r & ~pwm; // (R1)
   wire [7:0] cnt_inc = cnt_r + `TMR_ONE;
   wire [7:0] cnt_dec = cnt_r - `TMR_ONE;
   wire tov_ev = tick & ((mode == tmr_pkg::TMR_MODE_PHASE) ? (is_bot & ~up_r) : is_top); // (R7)
   wire upd_ocr = ~pwm | (tick & is_top & (up_r | (mode == tmr_pkg::TMR_MODE_FAST))); // (R7)

   logic [7:0] cnt_nxt;
   logic up_nxt;
   always_comb
   begin
      cnt_nxt = cnt_r;
      up_nxt = up_r;
      if (xfer_r[2])
         cnt_nxt = tmp_r[2];
      else if (tick)
      begin
         unique case (mode)
            tmr_pkg::TMR_MODE_CTC:
               cnt_nxt = match_ev ? `TMR_BOTTOM : cnt_inc; // (R4) (R7)
            tmr_pkg::TMR_MODE_PHASE:
            begin
               if (up_r & is_top)
               begin
                  cnt_nxt = cnt_dec;
                  up_nxt = 1'b0;
               end
               else if (~up_r & is_bot)
               begin
                  cnt_nxt = cnt_inc;
                  up_nxt = 1'b1;
               end
               else
                  cnt_nxt = up_r ? cnt_inc : cnt_dec;
            end
            default:
               cnt_nxt = cnt_inc;
         endcase
      end
      if (mode != tmr_pkg::TMR_MODE_PHASE)
         up_nxt = 1'b1;
   end

   // ----------------------------------------
   // waveform unit
   // ----------------------------------------
   logic oc_nxt;
   always_comb
   begin
      oc_nxt = oc_r;
      unique case (mode)
         tmr_pkg::TMR_MODE_FAST:
         begin
            if (com[1] & match_ev & ~special)
               oc_nxt = com[0]; // (R10) (R11)
            if (com[1] & tick & is_top)
               oc_nxt = ~com[0]; // (R10)
         end
         tmr_pkg::TMR_MODE_PHASE:
         begin
            if (com[1] & match_ev & ~special)
               oc_nxt = up_r ? com[0] : ~com[0]; // (R12)
            if (special & tick & is_top & up_r)
               oc_nxt = ~com[0]; // (R13)
         end
         default:
         begin
            if (match_ev | force_ev) // (R3)
            begin
               unique case (com)
                  2'h1: oc_nxt = ~oc_r; // (R9)
                  2'h2: oc_nxt = 1'b0;
                  2'h3: oc_nxt = 1'b1;
                  default: oc_nxt = oc_r;
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ctrl_r <= `TMR_RESET_BYTE;
         cnt_r <= `TMR_RESET_BYTE; // (R23)
         ocr_act_r <= `TMR_RESET_BYTE;
         up_r <= 1'b1;
         blk_r <= 1'b0;
         force_r <= 1'b0;
         oc_r <= 1'b0;
      end
      else
      begin
         if (xfer_r[0])
            ctrl_r <= {1'b0, tmp_r[0][6:0]}; // (R5)
         force_r <= xfer_r[0] & tmp_r[0][`TMR_CTRL_FORCE];
         cnt_r <= cnt_nxt;
         up_r <= up_nxt;
         if (upd_ocr)
            ocr_act_r <= tmp_r[1];
         if (xfer_r[2])
            blk_r <= 1'b1; // (R16)
         else if (tick)
            blk_r <= 1'b0;
         oc_r <= oc_nxt;
      end
   end

   // ----------------------------------------
   // software registers and flags
   // ----------------------------------------
   wire clr_ocf = do_wr & hit_flag & wbyte[`TMR_FLAG_OCF];
   wire clr_tov = do_wr & hit_flag & wbyte[`TMR_FLAG_TOV];

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         ext_clock_input_en_r <= 1'b0;
         as_r <= 1'b0;
         dir_r <= 1'b0;
         ocf_r <= 1'b0;
         tov_r <= 1'b0;
         compare_output_pin_oe_out <= 1'b0;
         compare_output_override_out <= 1'b0;
         ext_clock_input_en_out <= 1'b0;
         crystal_osc_run_out <= 1'b0;
      end
      else
      begin
         if (do_wr & hit_async_clock_status)
         begin
            ext_clock_input_en_r <= wbyte[`TMR_ASYNC_CLOCK_STATUS_EXT_CLOCK_INPUT_EN];
            as_r <= wbyte[`TMR_ASYNC_CLOCK_STATUS_AS];
         end
         if (do_wr & hit_dir)
            dir_r <= wbyte[0];
         // a hardware set in the same cycle as a clear wins
         ocf_r <= match_ev | (ocf_r & ~clr_ocf); // (R22) (R4)
         tov_r <= tov_ev | (tov_r & ~clr_tov); // (R22)
         compare_output_override_out <= (com != 2'h0); // (R8)
         compare_output_pin_oe_out <= (com != 2'h0) & dir_r; // (R8)
         ext_clock_input_en_out <= ext_clock_input_en_r & as_r; // (R18)
         crystal_osc_run_out <= as_r & ~ext_clock_input_en_r; // (R18)
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   // one wait cycle per access keeps read data registered
   wire [7:0] rbyte = hit_ctrl ? {1'b0, tmp_r[0][6:0]} : // (R5)
                      hit_cnt ? cnt_r :
                      hit_ocr ? tmp_r[1] :
                      hit_async_clock_status ? {3'h0, ext_clock_input_en_r, as_r, pend_r} :
                      hit_flag ? {6'h0, ocf_r, tov_r} :
                      hit_dir ? {7'h0, dir_r} : 8'h00;

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         wait_r <= ~((read_in | write_in) & wait_r);
         if (read_in & wait_r)
            rdata_r <= {24'h00_0000, rbyte};
      end
   end

   assign waitrequest_out = wait_r;
   assign readdata_out = rdata_r;
   assign compare_output_pin_out = oc_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   chk_force_pwm_off: assert property (force_r && pwm && !tick |=> $stable(oc_r)) // (R1)
      else $error("force strobe changed output in pwm mode");
   chk_force_no_flag: assert property (force_ev && !match_ev && !ocf_r && !clr_ocf |=> !ocf_r) // (R4)
      else $error("forced compare set match flag");
   chk_strobe_zero: assert property (read_in && hit_ctrl && wait_r |=> readdata_out[7] == 1'b0) // (R5)
      else $error("force strobe read as one");
   // the prescaler tick is registered, so the select must have been zero one cycle already
   chk_stop_holds: assert property (ctrl_r[`TMR_CTRL_CS_HI:`TMR_CTRL_CS_LO] == 3'h0 // (R15)
                                    && $past(ctrl_r[`TMR_CTRL_CS_HI:`TMR_CTRL_CS_LO]) == 3'h0
                                    && !xfer_r[2] |=> $stable(cnt_r))
      else $error("stopped timer counted");
   chk_write_blocks: assert property (xfer_r[2] ##1 !xfer_r[2] [*1] |-> !match_ev) // (R16)
      else $error("match after counter write");
   chk_ctc_clear: assert property (mode == tmr_pkg::TMR_MODE_CTC && match_ev && !xfer_r[2]
                                   |=> cnt_r == `TMR_BOTTOM) // (R7)
      else $error("clear-on-match did not clear counter");
   chk_pin_enable: assert property (##1 compare_output_pin_oe_out == $past((com != 2'h0) && dir_r)) // (R8)
      else $error("pin driver enable wrong");
   chk_fast_bottom: assert property (mode == tmr_pkg::TMR_MODE_FAST && com[1] && tick && is_top
                                     |=> oc_r == !$past(com[0])) // (R10)
      else $error("fast pwm bottom action wrong");
   chk_ovf_flag: assert property (tov_ev |=> tov_r ##1 (tov_r || $past(clr_tov))) // (R22)
      else $error("overflow flag not set");
   chk_bus_answer: assert property ((read_in || write_in) && wait_r |=> !wait_r ##1 wait_r)
      else $error("wait request did not pulse low for one cycle");
endmodule
`default_nettype wire

// ### rtl/tmr_prescale.sv
`include "tmr_consts.svh"
`default_nettype none
module tmr_prescale #(
   parameter int PRE_W = 10
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // source and selection
   input wire logic src_tick_in,
   input wire tmr_pkg::tmr_cs_t sel_in,
   // timer tick
   output logic tick_out
);
   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] mask;
   logic hit;

   // the divider runs free so that a new selection takes effect at once
   assign mask = (sel_in == tmr_pkg::TMR_CS_DIV8) ? `TMR_MASK_DIV8 :
                 (sel_in == tmr_pkg::TMR_CS_DIV32) ? `TMR_MASK_DIV32 :
                 (sel_in == tmr_pkg::TMR_CS_DIV64) ? `TMR_MASK_DIV64 :
                 (sel_in == tmr_pkg::TMR_CS_DIV128) ? `TMR_MASK_DIV128 :
                 (sel_in == tmr_pkg::TMR_CS_DIV256) ? `TMR_MASK_DIV256 :
                 `TMR_MASK_DIV1024;
   assign hit = (sel_in == tmr_pkg::TMR_CS_DIV1) ? 1'b1 :
                (sel_in == tmr_pkg::TMR_CS_STOP) ? 1'b0 : // (R15)
                ((pre_r & mask) == mask);

   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         pre_r <= '0;
         tick_out <= 1'b0;
      end
      else
      begin
         if (src_tick_in)
            pre_r <= pre_r + 1'b1;
         tick_out <= src_tick_in & hit; // (R14)
      end
   end
endmodule
`default_nettype wire
